// ### bench/edge_source.sv
/* pulse source standing in for the count pin or the crystal.
   assumes a burst is requested only while the source is idle. */
`timescale 1ns/1ps
module edge_source (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       go,
   input  wire logic [3:0] pulses,
   input  wire logic [3:0] half,
   output logic            pin,
   output logic            busy
);
   logic [4:0] edges_q, edges_d;
   logic [3:0] wait_q, wait_d;

   // odd edge count means high; the line rests low between bursts
   always_comb begin
      edges_d = edges_q;
      wait_d = wait_q;
      if (go && edges_q == 5'h0) begin
         edges_d = {pulses, 1'b0};
         wait_d = half;
      end else if (edges_q != 5'h0) begin
         if (wait_q == 4'h0) begin
            edges_d = edges_q - 5'h1;
            wait_d = half;
         end else begin
            wait_d = wait_q - 4'h1;
         end
      end
   end

   // burst state
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         edges_q <= 5'h0;
         wait_q <= 4'h0;
      end else begin
         edges_q <= edges_d;
         wait_q <= wait_d;
      end
   end

   // pin level and burst activity
   assign pin = edges_q[0];
   assign busy = edges_q != 5'h0;
endmodule

// ### bench/test_tmr_top.sv
/* self-checking bench for the timer: register reads are noted in
   queues and judged by a monitor. assumes a 40 MHz clock. */
`timescale 1ns/1ps
module test_tmr_top;
   localparam logic [35:0] T = 36'h800000000;
   logic        clk, rst_b, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        count_input_pin, crystal_in_pin, crystal_out_pin;
   logic        crystal_out_oe, internal_oscillator_or_lp_mode, sleep, pin5_data;
   logic        pin4_data, pin5_direction, pin4_direction, irq, wake;
   logic        timebase_ok, run, m;
   logic [1:0]  go, busy;
   logic [3:0]  num, hf;
   logic [3:0]  hb;
   logic [35:0] lo_q[$], hi_q[$], got, lo, hi;
   integer      seed = 53241;
   int          fails = 0, comparisons = 0, i, dv;
   logic [31:0] v;

   tmr_top u_tmr_top (
      .clk               (clk),
      .rst_b             (rst_b),
      .paddr             (paddr),
      .psel              (psel),
      .penable           (penable),
      .pwrite            (pwrite),
      .pwdata            (pwdata),
      .prdata            (prdata),
      .pready            (pready),
      .pslverr           (pslverr),
      .count_input_pin   (count_input_pin),
      .crystal_in_pin    (crystal_in_pin),
      .crystal_out_pin   (crystal_out_pin),
      .crystal_out_oe    (crystal_out_oe),
      .internal_oscillator_or_lp_mode (internal_oscillator_or_lp_mode),
      .sleep             (sleep),
      .pin5_data         (pin5_data),
      .pin4_data         (pin4_data),
      .pin5_direction    (pin5_direction),
      .pin4_direction    (pin4_direction),
      .irq               (irq),
      .wake              (wake),
      .timebase_ok       (timebase_ok)
   );
   edge_source u_count (.clk(clk), .rst_b(rst_b), .go(go[0]),
      .pulses(num), .half(hf), .pin(count_input_pin), .busy(busy[0]));
   edge_source u_xtal (.clk(clk), .rst_b(rst_b), .go(go[1]),
      .pulses(num), .half(hf), .pin(crystal_in_pin), .busy(busy[1]));

   // 25 ns clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic test_done;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // one apb transfer; reads leave a note with the accepted range
   task automatic xfer(input logic [7:0] a, input logic w,
      input logic [31:0] d, input logic [35:0] l, input logic [35:0] h);
      if (!w) begin
         lo_q.push_back(l);
         hi_q.push_back(h);
      end
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d, 36'h0, 36'h0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [35:0] e);
      xfer(a, 1'b0, 32'h0, e, e);
   endtask

   function automatic logic [31:0] ctl(input logic s, input logic b,
      input logic x, input logic [1:0] p, input logic a);
      ctl = 32'h1 | s << tmr_pkg::CTRL_SRC | b << tmr_pkg::CTRL_BYP
         | x << tmr_pkg::CTRL_XTAL | p << tmr_pkg::CTRL_PS
         | a << tmr_pkg::CTRL_ACS;
   endfunction

   // burst on one source; the extra wait lets the synchroniser drain
   task automatic pulse(input logic x, input logic [3:0] n);
      num <= n;
      hf <= 4'h2 | 4'($random(seed));
      go <= {x, !x};
      @(posedge clk);
      go <= 2'b0;
      @(posedge clk);
      while (busy != 2'b0) @(posedge clk);
      repeat (6) @(posedge clk);
   endtask

   // judge each read answer against the oldest note
   always @(posedge clk) begin
      if (psel && penable && pready && !pwrite) begin
         got = {timebase_ok, wake, irq, pslverr, prdata};
         lo = lo_q.pop_front();
         hi = hi_q.pop_front();
         comparisons++;
         if (((got >= lo) && (got <= hi)) !== 1'b1) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, lo);
         end
      end
   end

   // main sequence
   initial begin
      {rst_b, psel, penable, pwrite, sleep, pin4_data, go} = '0;
      {paddr, pwdata, num, hf} = '0;
      internal_oscillator_or_lp_mode = 1'b1;
      pin5_data = 1'b1;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rd(tmr_pkg::OFS_CTRL, T);
      rd(tmr_pkg::OFS_PORT, T | 8'h23);
      rd(8'h18, T | 36'h100000000);
      for (i = 0; i < 4; i++) begin
         v = $random(seed);
         wr(tmr_pkg::OFS_LOW, v[7:0]);
         wr(tmr_pkg::OFS_HIGH, v[15:8]);
         rd(tmr_pkg::OFS_LOW, T | v[7:0]);
         rd(tmr_pkg::OFS_HIGH, T | v[15:8]);
      end
      // internal sources at every prescale code
      for (i = 0; i < 8; i++) begin
         wr(tmr_pkg::OFS_LOW, 0);
         wr(tmr_pkg::OFS_HIGH, 0);
         wr(tmr_pkg::OFS_CTRL, ctl(0, 0, 0, i[1:0], i[2]));
         repeat (128) @(posedge clk);
         wr(tmr_pkg::OFS_CTRL, 0);
         dv = (i[2] ? 1 : 4) << i[1:0];
         xfer(tmr_pkg::OFS_LOW, 0, 0, T | 128 / dv, T | 136 / dv + 1);
      end
      // pin counting: sync or bypass, awake or asleep
      for (i = 0; i < 4; i++) begin
         m = i != 0;
         run = !(i[1] && !i[0]);
         hb = {~i[0], i[1] & run & m, run & m, 1'b0};
         wr(tmr_pkg::OFS_MASK, m);
         sleep <= i[1];
         wr(tmr_pkg::OFS_LOW, 8'hFF);
         wr(tmr_pkg::OFS_HIGH, 8'hFF);
         wr(tmr_pkg::OFS_CTRL, ctl(1, i[0], 0, 0, 0));
         pulse(1'b0, 4'h2);
         rd(tmr_pkg::OFS_LOW, {hb, 24'h0, run ? 8'h00 : 8'hFF});
         rd(tmr_pkg::OFS_STAT, {hb, 31'h0, run});
         wr(tmr_pkg::OFS_CTRL, 0);
         sleep <= 1'b0;
         wr(tmr_pkg::OFS_STAT, 1);
         rd(tmr_pkg::OFS_STAT, T);
      end
      // crystal: pins taken over, start-up wait, then count
      wr(tmr_pkg::OFS_PORT, 0);
      rd(tmr_pkg::OFS_PORT, T | 8'h20);
      // no crystal and no time base loss outside internal_oscillator or lp mode
      internal_oscillator_or_lp_mode <= 1'b0;
      wr(tmr_pkg::OFS_CTRL, ctl(1, 0, 1, 0, 0) ^ 32'h1);
      rd(tmr_pkg::OFS_PORT, T | 8'h20);
      wr(tmr_pkg::OFS_CTRL, ctl(0, 0, 0, 0, 1) ^ 32'h1);
      rd(tmr_pkg::OFS_CTRL, T | 8'h40);
      internal_oscillator_or_lp_mode <= 1'b1;
      rd(tmr_pkg::OFS_CTRL, 36'h40);
      wr(tmr_pkg::OFS_CTRL, ctl(1, 0, 1, 0, 0) ^ 32'h1);
      rd(tmr_pkg::OFS_PORT, T | 8'h03);
      repeat (16) @(posedge clk);
      wr(tmr_pkg::OFS_LOW, 0);
      wr(tmr_pkg::OFS_CTRL, ctl(1, 0, 1, 0, 0));
      pulse(1'b1, 4'h3);
      rd(tmr_pkg::OFS_LOW, T | 8'h02);
      test_done;
   end

   // watchdog well beyond the few thousand cycles needed
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      test_done;
   end
endmodule

// ### bench/tmr_checker.sv
/* assertions on the timer's bus, crystal, port and wake outputs.
   assumes one clock domain and an active low reset. */
`timescale 1ns/1ps
module tmr_checker (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        crystal_in_pin,
   input wire logic        crystal_out_pin,
   input wire logic        crystal_out_oe,
   input wire logic        sleep,
   input wire logic        pin5_direction,
   input wire logic        pin4_direction,
   input wire logic        irq,
   input wire logic        wake
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   // bus answer: one wait state, then a single cycle
   ready_wait_a:
   assert property (psel && $rose(penable) |-> !pready ##1 pready)
      else $error("ready not in second access cycle");
   ready_pulse_a:
   assert property (pready |=> !pready) else $error("ready held");
   ready_idle_a:
   assert property (!psel |=> !pready) else $error("ready without select");
   err_read_a:
   assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("bad error answer");

   // crystal in use: pins turned to input, inverter running
   dir_forced_a:
   assert property (crystal_out_oe |-> pin5_direction && pin4_direction)
      else $error("direction not forced");
   xtal_drive_a:
   assert property (crystal_out_oe && $past(crystal_out_oe) |->
      crystal_out_pin == !$past(crystal_in_pin))
      else $error("crystal output not inverted");

   // wake only from an asleep core with a pending unmasked rollover
   wake_cause_a:
   assert property (wake |-> irq && $past(sleep))
      else $error("wake without cause");
   wake_irq_a:
   assert property (irq && $past(sleep) |-> wake)
      else $error("wake missing");

   cover property (wake);
   cover property ($rose(irq));
   cover property (pslverr);
endmodule

bind tmr_top tmr_checker u_tmr_checker (.*);

// ### rtl/prescale_if.sv
/*
 * interface between the timer core and its prescale divider.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface prescale_if;
   logic       tick;
   logic       clear;
   logic [1:0] sel;
   logic       pulse;

   modport owner   (output tick, output clear, output sel, input pulse);
   modport divider (input tick, input clear, input sel, output pulse);
endinterface

// ### rtl/tmr_edge.sv
/*
 * count input conditioner: two-stage synchroniser or a single-stage
 * bypass path, then rising and falling edge detection.
 * assumes the raw input is a plain level from a pin.
 */
`timescale 1ns/1ps
module tmr_edge (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic raw,
   input  wire logic bypass,
   output logic      rise,
   output logic      fall,
   output logic      level
);

   logic sync1_q, sync2_q, sync3_q;
   logic byp1_q, byp2_q;
   logic sync1_d, sync2_d, sync3_d, byp1_d, byp2_d;
   logic prev;

   always_comb begin
      sync1_d = raw;
      sync2_d = sync1_q;
      sync3_d = sync2_q;
      byp1_d  = raw;
      byp2_d  = byp1_q;
      level   = bypass ? byp1_q : sync2_q;
      prev    = bypass ? byp2_q : sync3_q;
      rise    = level & ~prev;
      fall    = ~level & prev;
   end

   // mode switch slip
   // mode switch may drop or add one edge, accepted
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         sync3_q <= 1'b0;
         byp1_q  <= 1'b0;
         byp2_q  <= 1'b0;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         sync3_q <= sync3_d;
         byp1_q  <= byp1_d;
         byp2_q  <= byp2_d;
      end
   end

endmodule

// ### rtl/tmr_pkg.sv
/*
 * shared constants for the 16-bit timer/counter: register offsets,
 * control field positions, reset values and clock source kinds.
 * assumes a 40 MHz system clock that also serves as fosc.
 */
package tmr_pkg;

   // system clock, used as fosc
   localparam int unsigned CLK_HZ = 40_000_000;

   localparam int COUNT_W = 16;
   localparam int BYTE_W  = 8;
   localparam int ADDR_W  = 8;
   localparam int DATA_W  = 32;

   // register byte offsets on the apb bus
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_LOW  = 8'h04;
   localparam logic [7:0] OFS_HIGH = 8'h08;
   localparam logic [7:0] OFS_STAT = 8'h0C;
   localparam logic [7:0] OFS_MASK = 8'h10;
   localparam logic [7:0] OFS_PORT = 8'h14;

   // control register layout
   localparam int CTRL_W    = 7;
   localparam int CTRL_RUN  = 0;
   localparam int CTRL_SRC  = 1;
   localparam int CTRL_BYP  = 2;
   localparam int CTRL_XTAL = 3;
   localparam int CTRL_PS   = 4;
   localparam int CTRL_ACS  = 6;
   localparam logic [6:0] CTRL_RST = 7'h00;

   // status and mask layout
   localparam int STAT_ROLL = 0;

   // port register: directions in [1:0], pin data in [5:4]
   localparam int PORT_DATA = 4;
   localparam logic [1:0] PORT_DIR_RST = 2'h3;
   localparam logic [1:0] PIN_DIR_IN   = 2'h3;

   // fosc/4 phase counter wraps here
   localparam logic [1:0] PHASE_LAST = 2'h3;
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;

   typedef enum logic [1:0] {
      SRC_QUARTER,
      SRC_FULL,
      SRC_EXT
   } clk_src_t;

endpackage

// ### rtl/tmr_prescaler.sv
/*
 * prescale divider: passes every 1st, 2nd, 4th or 8th input tick.
 * assumes the owner clears it on any count write; not software visible.
 */
`timescale 1ns/1ps
module tmr_prescaler #(
   parameter int PS_W = 3
) (
   input  wire logic  clk,
   input  wire logic  rst_b,
   prescale_if.divider ps
);

   logic [PS_W-1:0] cnt_q;
   logic [PS_W-1:0] cnt_d;
   logic [PS_W-1:0] limit;

   generate
      if (PS_W < 3) begin : g_chk
         $error("prescale counter too narrow for divide by 8");
      end
   endgenerate

   // code n gives two to n
   // limit is ratio minus one, a run of ones
   always_comb begin
      limit    = ~({PS_W{1'b1}} << ps.sel);
      ps.pulse = ps.tick && (cnt_q == limit);
      cnt_d    = cnt_q;
      if (ps.clear) begin
         cnt_d = '0;
      end else if (ps.tick) begin
         cnt_d = (cnt_q == limit) ? '0 : cnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

endmodule

// ### rtl/tmr_top.sv
/*
 * 16-bit timer/counter with prescaler, crystal oscillator control,
 * sync or async external counting, rollover interrupt and apb slave.
 * assumes clk is fosc at 40 MHz and all pins are synchronous to clk.
 */
// Design decisions made here: register access over APB and the address map.
// Functional notes
// - 16-bit counter, bytes writable directly
// - source: fosc/4, fosc or pin
// - internal source counts per prescaled tick
// - external rising edges, sync or not
// - falling edge needed before first count
// - prescaler divides by 1, 2, 4, 8
// - prescaler hidden, cleared on byte write
// - crystal oscillator enabled, runs in sleep
// - crystal usable only in internal_oscillator/lp mode
// - crystal forces pin directions input
// - bypass bit skips the synchroniser
// - async mode counts, wakes in sleep
// - no capture time base in some modes
// - rollover ffff to 0000 sets flag
// - prescale code 00..11 gives 1..8
// - bypass bit ignored with internal source
`timescale 1ns/1ps
module tmr_top (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        count_input_pin,
   input  wire logic        crystal_in_pin,
   output logic             crystal_out_pin,
   output logic             crystal_out_oe,
   input  wire logic        internal_oscillator_or_lp_mode,
   input  wire logic        sleep,
   input  wire logic        pin5_data,
   input  wire logic        pin4_data,
   output logic             pin5_direction,
   output logic             pin4_direction,
   output logic             irq,
   output logic             wake,
   output logic             timebase_ok
);

   logic [6:0]  ctrl_q, ctrl_d;
   logic [15:0] count_q, count_d;
   logic        stat_q, stat_d;
   logic        mask_q, mask_d;
   logic [1:0]  dir_sw_q, dir_sw_d;
   logic [1:0]  phase_q, phase_d;
   logic        armed_q, armed_d;
   logic        lvl_dis_q, lvl_dis_d;
   logic        run_prev_q;
   logic        pready_q, pready_d;
   logic        pslverr_q, pslverr_d;
   logic [31:0] prdata_q, prdata_d;
   logic        irq_q, irq_d;
   logic        wake_q, wake_d;
   logic        tb_q, tb_d;
   logic [1:0]  pdir_q, pdir_d;
   logic        xout_q, xout_d;
   logic        xoe_q, xoe_d;

   logic        run, src_ext, bypass, acs, use_xtal, async_mode;
   logic        frozen, ext_raw, ext_rise, ext_fall, ext_level;
   logic        wr_fire, setup_acc, hit;
   logic        wr_low, wr_high, wr_ctrl, wr_stat, wr_mask, wr_port;
   logic        inc, roll;
   logic [31:0] rd_word;
   tmr_pkg::clk_src_t src;

   prescale_if ps ();

   tmr_prescaler #(
      .PS_W (3)
   ) u_tmr_prescaler (
      .clk   (clk),
      .rst_b (rst_b),
      .ps    (ps)
   );

   tmr_edge u_tmr_edge (
      .clk    (clk),
      .rst_b  (rst_b),
      .raw    (ext_raw),
      .bypass (bypass),
      .rise   (ext_rise),
      .fall   (ext_fall),
      .level  (ext_level)
   );

   // control field decode
   always_comb begin
      run      = ctrl_q[tmr_pkg::CTRL_RUN];
      src_ext  = ctrl_q[tmr_pkg::CTRL_SRC];
      acs      = ctrl_q[tmr_pkg::CTRL_ACS];
      bypass   = src_ext & ctrl_q[tmr_pkg::CTRL_BYP];
      async_mode = bypass;
      use_xtal = ctrl_q[tmr_pkg::CTRL_XTAL] & internal_oscillator_or_lp_mode;
      ext_raw  = use_xtal ? crystal_in_pin : count_input_pin;
      if (src_ext) begin
         src = tmr_pkg::SRC_EXT;
      end else if (acs) begin
         src = tmr_pkg::SRC_FULL;
      end else begin
         src = tmr_pkg::SRC_QUARTER;
      end
      // only async mode runs in sleep
      frozen = sleep & ~async_mode;
   end

   // apb decode; one wait state, write lands when pready is high
   // fixed timing keeps the slave free of stall logic, at the cost
   // of one extra cycle on every access
   always_comb begin
      setup_acc = psel & penable & ~pready_q;
      wr_fire   = psel & penable & pwrite & pready_q;
      hit = (paddr == tmr_pkg::OFS_CTRL) || (paddr == tmr_pkg::OFS_LOW) ||
            (paddr == tmr_pkg::OFS_HIGH) || (paddr == tmr_pkg::OFS_STAT) ||
            (paddr == tmr_pkg::OFS_MASK) || (paddr == tmr_pkg::OFS_PORT);
      wr_ctrl = wr_fire && (paddr == tmr_pkg::OFS_CTRL);
      wr_low  = wr_fire && (paddr == tmr_pkg::OFS_LOW);
      wr_high = wr_fire && (paddr == tmr_pkg::OFS_HIGH);
      wr_stat = wr_fire && (paddr == tmr_pkg::OFS_STAT);
      wr_mask = wr_fire && (paddr == tmr_pkg::OFS_MASK);
      wr_port = wr_fire && (paddr == tmr_pkg::OFS_PORT);
   end

   // read mux; unmapped reads zero
   // reads have no side effects; the flag clears only
   // when software writes a one to it
   always_comb begin
      rd_word = '0;
      unique case (paddr)
         tmr_pkg::OFS_CTRL: rd_word[6:0] = ctrl_q;
         tmr_pkg::OFS_LOW:  rd_word[7:0] = count_q[7:0];
         tmr_pkg::OFS_HIGH: rd_word[7:0] = count_q[15:8];
         tmr_pkg::OFS_STAT: rd_word[tmr_pkg::STAT_ROLL] = stat_q;
         tmr_pkg::OFS_MASK: rd_word[tmr_pkg::STAT_ROLL] = mask_q;
         tmr_pkg::OFS_PORT: begin
            rd_word[1:0] = pdir_q;
            rd_word[tmr_pkg::PORT_DATA +: 2] =
               use_xtal ? 2'h0 : {pin5_data, pin4_data};
         end
         default: rd_word = '0;
      endcase
   end

   // bus answer registers
   // read data held between transfers to save toggling
   always_comb begin
      pready_d  = setup_acc;
      prdata_d  = prdata_q;
      pslverr_d = 1'b0;
      if (setup_acc) begin
         prdata_d  = pwrite ? '0 : rd_word;
         pslverr_d = ~hit;
      end
   end

   // tick source into the prescaler
   // the phase counter is not reset by control writes, so the first
   // fosc/4 tick after a start may come up to three clocks early
   always_comb begin
      phase_d = phase_q + 2'h1;
      ps.tick  = 1'b0;
      ps.clear = wr_low | wr_high;
      ps.sel   = ctrl_q[tmr_pkg::CTRL_PS +: 2];
      unique case (src)
         tmr_pkg::SRC_QUARTER: ps.tick = (phase_q == tmr_pkg::PHASE_LAST);
         tmr_pkg::SRC_FULL:    ps.tick = 1'b1;
         tmr_pkg::SRC_EXT:     ps.tick = ext_rise & armed_q;
      endcase
      ps.tick = ps.tick & run & ~frozen;
   end

   // falling-edge arming for counter mode
   // a stale high level after a write or restart must not
   // pass for the first counting edge
   always_comb begin
      armed_d   = armed_q;
      lvl_dis_d = lvl_dis_q;
      if (run_prev_q & ~run) begin
         lvl_dis_d = ext_level;
      end
      // disarm on write or level drop
      if (wr_low | wr_high) begin
         armed_d = 1'b0;
      end else if (~run_prev_q & run & lvl_dis_q & ~ext_level) begin
         armed_d = 1'b0;
      end else if (run & ext_fall) begin
         armed_d = 1'b1;
      end
   end

   // counter and rollover
   // no read latch: software reading low then high
   // may see a carry between the two reads
   always_comb begin
      inc     = ps.pulse;
      roll    = inc && (count_q == tmr_pkg::COUNT_MAX);
      count_d = inc ? count_q + 16'h0001 : count_q;
      if (wr_low) begin
         count_d[7:0] = pwdata[7:0];
      end
      if (wr_high) begin
         count_d[15:8] = pwdata[7:0];
      end
   end

   // software registers and status
   always_comb begin
      ctrl_d   = wr_ctrl ? pwdata[6:0] : ctrl_q;
      mask_d   = wr_mask ? pwdata[tmr_pkg::STAT_ROLL] : mask_q;
      dir_sw_d = wr_port ? pwdata[1:0] : dir_sw_q;
      stat_d = (stat_q & ~(wr_stat & pwdata[tmr_pkg::STAT_ROLL])) | roll;
      // irq trails the flag by one clock
      irq_d  = stat_q & mask_q;
      wake_d = sleep & stat_q & mask_q;
      tb_d = ~async_mode & ~(~src_ext & acs & internal_oscillator_or_lp_mode);
      pdir_d = use_xtal ? tmr_pkg::PIN_DIR_IN : dir_sw_q;
      xout_d = ~crystal_in_pin;
      xoe_d  = use_xtal;
   end

   // state registers
   // reset branch loads constants only
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q     <= tmr_pkg::CTRL_RST;
         count_q    <= '0;
         stat_q     <= 1'b0;
         mask_q     <= 1'b0;
         dir_sw_q   <= tmr_pkg::PORT_DIR_RST;
         phase_q    <= '0;
         armed_q    <= 1'b0;
         lvl_dis_q  <= 1'b0;
         run_prev_q <= 1'b0;
         pready_q   <= 1'b0;
         pslverr_q  <= 1'b0;
         prdata_q   <= '0;
         irq_q      <= 1'b0;
         wake_q     <= 1'b0;
         tb_q       <= 1'b0;
         pdir_q     <= tmr_pkg::PORT_DIR_RST;
         xout_q     <= 1'b0;
         xoe_q      <= 1'b0;
      end else begin
         ctrl_q     <= ctrl_d;
         count_q    <= count_d;
         stat_q     <= stat_d;
         mask_q     <= mask_d;
         dir_sw_q   <= dir_sw_d;
         phase_q    <= phase_d;
         armed_q    <= armed_d;
         lvl_dis_q  <= lvl_dis_d;
         run_prev_q <= run;
         pready_q   <= pready_d;
         pslverr_q  <= pslverr_d;
         prdata_q   <= prdata_d;
         irq_q      <= irq_d;
         wake_q     <= wake_d;
         tb_q       <= tb_d;
         pdir_q     <= pdir_d;
         xout_q     <= xout_d;
         xoe_q      <= xoe_d;
      end
   end

   // outputs straight from flops
   assign prdata          = prdata_q;
   assign pready          = pready_q;
   assign pslverr         = pslverr_q;
   assign irq             = irq_q;
   assign wake            = wake_q;
   assign timebase_ok     = tb_q;
   assign pin5_direction  = pdir_q[1];
   assign pin4_direction  = pdir_q[0];
   assign crystal_out_pin = xout_q;
   assign crystal_out_oe  = xoe_q;

endmodule
